//--- bdm_code_if.sv
// Handshake between the mode sequencer and the fault code sender
`timescale 1ns/100ps
interface bdm_code_if;
  // Start of a fault, one cycle
  logic start;
  // Faults to report at start
  logic [8:0] flags;
  // Pull-down request for the pin
  logic pd;
  // Codes have been sent
  logic done;
  modport seq (output start, output flags, input pd, input done);
  modport send (input start, input flags, output pd, output done);
endinterface

//--- bdm_host.sv
// Host model on the disable/fault pin: pull-up with an optional hold-low
`timescale 1ns/100ps
module bdm_host #(
  parameter int LAG = 3
) (
  // Clock
  input wire logic mclk,
  // Request to hold the pin low
  input wire logic hold,
  // Device open-drain side
  input wire logic dev_o,
  input wire logic dev_oe,
  // Resolved pin level
  output logic pin
);
  // Release lags the request, like a slow host
  logic [7:0] cnt_q = 8'h00;
  // Lag counter for the release
  always_ff @(posedge mclk) begin
    if (hold) begin
      cnt_q <= 8'(LAG);
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  // Pull-up wins unless a party pulls low
  assign pin = !(hold || cnt_q != 8'h00 || (dev_oe && !dev_o));
endmodule

//--- bdm_pkg.sv
// Shared constants and types of the bias driver mode and fault sequencer
package bdm_pkg;
  // Clock period in ns (40 MHz)
  localparam int CLK_NS = 25;
  // Soft-start interval, 1.5 ms
  localparam int SS_US = 1500;
  localparam int SS_CYC = SS_US * 1000 / CLK_NS;
  // Sustained overcurrent time, 2.1 ms
  localparam int OC1_US = 2100;
  localparam int OC1_CYC = OC1_US * 1000 / CLK_NS;
  // Peak overcurrent time, 100 ns, least time rounds up
  localparam int OC2_NS = 100;
  localparam int OC2_CYC = (OC2_NS + CLK_NS - 1) / CLK_NS;
  // Input overvoltage time, 1.3 us, least time rounds up
  localparam int OV_NS = 1300;
  localparam int OV_CYC = (OV_NS + CLK_NS - 1) / CLK_NS;
  // Code start delay, 10 us
  localparam int CODE_DLY_US = 10;
  localparam int CODE_DLY_CYC = CODE_DLY_US * 1000 / CLK_NS;
  // Lead and separator high interval, 100 us
  localparam int LEAD_US = 100;
  localparam int LEAD_CYC = LEAD_US * 1000 / CLK_NS;
  // Code pulse width, 10 us (50 kHz, 50 %)
  localparam int PULSE_US = 10;
  localparam int PULSE_CYC = PULSE_US * 1000 / CLK_NS;
  // Retry wait in fault, 100 ms
  localparam int RETRY_MS = 100;
  localparam int RETRY_CYC = RETRY_MS * 1000000 / CLK_NS;
  // Fault flag positions, code is position plus one
  localparam int NF = 9;
  localparam int F_OC1 = 0;
  localparam int F_OC2 = 1;
  localparam int F_OV = 2;
  localparam int F_TSD = 3;
  localparam int F_RANGE = 4;
  localparam int F_OPEN = 5;
  localparam int F_SHORT = 6;
  localparam int F_RT = 7;
  localparam int F_TRIM = 8;
  // Flag mask while the trim memory is bad
  localparam logic [NF-1:0] TRIM_MASK = 9'h100;
  // Register offsets and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CTRL_SYNC_BIT = 0;
  localparam logic CTRL_RST = 1'h1;
  localparam int STAT_ST_LSB = 16;
  // Operating modes, one-hot
  typedef enum logic [6:0] {
    ST_LOCK = 7'h01,
    ST_PWR = 7'h02,
    ST_WAIT = 7'h04,
    ST_SOFT = 7'h08,
    ST_RUN = 7'h10,
    ST_DIS = 7'h20,
    ST_FLT = 7'h40
  } bdm_state_t;
endpackage

//--- bdm_qual.sv
// Per-fault qualification delays
`timescale 1ns/100ps
module bdm_qual #(
  parameter int N = 9,
  parameter int CW = 17,
  parameter int DLY [N] = '{default: 0}
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Raw detector levels and count hold
  input wire logic [N-1:0] raw,
  input wire logic [N-1:0] hold,
  // Qualified faults
  output logic [N-1:0] qual
);
  for (genvar i = 0; i < N; i++) begin : g_q
    // Time this fault's detector has stood
    logic [CW-1:0] cnt_q;
    if (DLY[i] >= 2 ** CW) begin : g_chk
      $error("bdm_qual: delay too long for counter");
    end
    // Count while raw, freeze on hold, clear otherwise
    always_ff @(posedge mclk) begin
      if (reset || (!raw[i] && !hold[i])) begin
        cnt_q <= '0;
      end else if (raw[i] && cnt_q != CW'(DLY[i])) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
    // Qualified once the delay has fully passed
    assign qual[i] = raw[i] && (cnt_q == CW'(DLY[i]));
    if (DLY[i] > 0 && DLY[i] < 300) begin : g_a
      // A held count freezes, so a held cycle back then still counts as stood
      qual_delay_a: assert property (@(posedge mclk) disable iff (reset)
        (qual[i] && !hold[i]) |-> $past(raw[i] || hold[i], DLY[i]))
        else $error("fault qualified before its delay");
    end
  end
endmodule

//--- bdm_send.sv
// Fault code pulse train sender for the disable/fault pin
`timescale 1ns/100ps
module bdm_send #(
  parameter int DLY = bdm_pkg::CODE_DLY_CYC,
  parameter int LEAD = bdm_pkg::LEAD_CYC,
  parameter int PW = bdm_pkg::PULSE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Link to the sequencer
  bdm_code_if.send cif
);
  typedef enum logic [4:0] {
    SD_IDLE = 5'h01,
    SD_WAIT = 5'h02,
    SD_GAP = 5'h04,
    SD_LOW = 5'h08,
    SD_HIGH = 5'h10
  } bdm_sstate_t;
  if (DLY < 1 || LEAD < 1 || PW < 1 || LEAD >= 4096 || DLY >= 4096 || PW >= 4096) begin : g_chk
    $error("bdm_send: timing out of range");
  end
  bdm_sstate_t st_q; // Sender state
  logic [11:0] tm_q; // Interval timer
  logic [8:0] fl_q; // Codes still to send
  logic [3:0] n_q; // Pulses left in code
  logic pd_q; // Pull-down on
  logic done_q; // All codes sent
  logic [3:0] low_idx; // First pending code
  // Lowest pending flag gives the next code
  always_comb begin
    low_idx = 4'h0;
    for (int k = 8; k >= 0; k--) begin
      if (fl_q[k]) begin
        low_idx = 4'(k);
      end
    end
  end
  // Pulse train sequence
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= SD_IDLE;
      tm_q <= 12'h000;
      fl_q <= 9'h000;
      n_q <= 4'h0;
      pd_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (tm_q != 12'h000) begin
        tm_q <= tm_q - 12'h001;
      end
      case (st_q)
        SD_IDLE: begin
          if (cif.start) begin
            st_q <= SD_WAIT;
            tm_q <= 12'(DLY - 1);
            fl_q <= cif.flags;
            pd_q <= 1'b1;
            done_q <= 1'b0;
          end
        end
        SD_WAIT: begin
          if (tm_q == 12'h000) begin
            st_q <= SD_GAP;
            tm_q <= 12'(LEAD - 1);
            pd_q <= 1'b0;
          end
        end
        SD_GAP: begin
          if (tm_q == 12'h000) begin
            if (fl_q == 9'h000) begin
              // Train over, pin stays pulled low
              st_q <= SD_IDLE;
              pd_q <= 1'b1;
              done_q <= 1'b1;
            end else begin
              st_q <= SD_LOW;
              tm_q <= 12'(PW - 1);
              n_q <= low_idx + 4'h1;
              fl_q[low_idx] <= 1'b0;
              pd_q <= 1'b1;
            end
          end
        end
        SD_LOW: begin
          if (tm_q == 12'h000) begin
            n_q <= n_q - 4'h1;
            pd_q <= 1'b0;
            if (n_q == 4'h1) begin
              // Separator before next code
              st_q <= SD_GAP;
              tm_q <= 12'(LEAD - 1);
            end else begin
              st_q <= SD_HIGH;
              tm_q <= 12'(PW - 1);
            end
          end
        end
        SD_HIGH: begin
          if (tm_q == 12'h000) begin
            st_q <= SD_LOW;
            tm_q <= 12'(PW - 1);
            pd_q <= 1'b1;
          end
        end
        default: begin
          st_q <= SD_IDLE;
        end
      endcase
    end
  end
  assign cif.pd = pd_q;
  assign cif.done = done_q;
endmodule

//--- bdm_seq.sv
// Mode and fault sequencer of the isolated bias transformer driver
`timescale 1ns/100ps
module bdm_seq #(
  parameter int SS_CYC = bdm_pkg::SS_CYC,
  parameter int OC1_CYC = bdm_pkg::OC1_CYC,
  parameter int RETRY_CYC = bdm_pkg::RETRY_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Supply and regulator detectors
  input wire logic supply_ok,
  input wire logic reg_ok,
  input wire logic trim_bad,
  // Fault detectors
  input wire logic oc_low,
  input wire logic ls_on,
  input wire logic oc_peak,
  input wire logic ov_det,
  input wire logic tsd_det,
  input wire logic ocdt_check,
  input wire logic ocdt_high,
  input wire logic ocdt_mid,
  input wire logic ocdt_low,
  input wire logic rt_low,
  // Frequency source
  input wire logic [11:0] freq_pin_code,
  input wire logic sync_present,
  // Disable/fault pin
  input wire logic disable_fault_pin_i,
  output logic disable_fault_pin_o,
  output logic disable_fault_pin_oe,
  // Power stage and supply controls
  output logic half_bridge_switch_node_en,
  output logic [11:0] sw_half_period,
  output logic sw_sync_sel,
  output logic internal_regulator_en,
  output logic disabled_supply_current,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  if (SS_CYC < 16 || SS_CYC >= 2 ** 17 || OC1_CYC < 1 || OC1_CYC >= 2 ** 17
      || RETRY_CYC < 2 || RETRY_CYC >= 2 ** 22) begin : g_chk
    $error("bdm_seq: count parameter out of range");
  end
  localparam int NF = bdm_pkg::NF;
  localparam int SUB_CYC = SS_CYC / 8;

  bdm_pkg::bdm_state_t st_q; // Operating mode
  bdm_pkg::bdm_state_t st_d; // Next mode
  logic [16:0] ss_q; // Soft-start elapsed
  logic [16:0] sub_q; // Time within a step
  logic [3:0] step_q; // Soft-start step, 0 to 8
  logic [21:0] rt_q; // Time spent in fault
  logic [11:0] per_q; // Switching half period
  logic [16:0] prod; // Ramped half period
  logic [NF-1:0] raw; // Detector levels
  logic [NF-1:0] hold; // Count freeze per fault
  logic [NF-1:0] qual; // Qualified faults
  logic [NF-1:0] mask; // Faults that count
  logic [NF-1:0] qual_m; // Masked new faults
  logic [NF-1:0] raw_m; // Masked levels
  logic [NF-1:0] set_v; // Faults to latch now
  logic [NF-1:0] lat_q; // Latched faults
  logic trim_q; // Trim memory bad
  logic trim_seen_q; // Trim check done
  logic chk_go; // Pin rose, recheck now
  logic chk_bad; // Recheck found a fault
  logic clr; // Leaving the fault state
  logic ctrl_q; // Sync allowed
  logic ack_q; // Bus answer
  logic [31:0] dat_q; // Bus read data
  logic req; // New bus request

  bdm_code_if cif ();

  // Detector map, all inputs taken as synchronous
  always_comb begin
    raw = '0;
    hold = '0;
    raw[bdm_pkg::F_OC1] = oc_low && ls_on;
    hold[bdm_pkg::F_OC1] = !ls_on;
    raw[bdm_pkg::F_OC2] = oc_peak;
    raw[bdm_pkg::F_OV] = ov_det;
    raw[bdm_pkg::F_TSD] = tsd_det;
    raw[bdm_pkg::F_RANGE] = ocdt_check && ocdt_mid;
    raw[bdm_pkg::F_OPEN] = !ocdt_check && ocdt_high;
    raw[bdm_pkg::F_SHORT] = ocdt_low;
    raw[bdm_pkg::F_RT] = rt_low;
    raw[bdm_pkg::F_TRIM] = trim_q;
  end

  // Qualification delays per fault
  bdm_qual #(
    .N(NF),
    .CW(17),
    .DLY('{OC1_CYC, bdm_pkg::OC2_CYC, bdm_pkg::OV_CYC, 0, 0, 0, 0, 0, 0})
  ) u_qual (
    .mclk(mclk),
    .reset(reset),
    .raw(raw),
    .hold(hold),
    .qual(qual)
  );

  // Trim error hides every other fault
  assign mask = trim_q ? bdm_pkg::TRIM_MASK : '1;
  assign qual_m = qual & mask;
  assign raw_m = raw & mask;
  assign chk_go = (st_q == bdm_pkg::ST_WAIT) && disable_fault_pin_i;
  assign chk_bad = |((lat_q | raw) & mask);
  assign set_v = qual_m | (chk_go ? raw_m : '0);
  assign clr = (st_q == bdm_pkg::ST_FLT) && (st_d != bdm_pkg::ST_FLT);

  // Mode transitions
  always_comb begin
    st_d = st_q;
    if (!supply_ok) begin
      st_d = bdm_pkg::ST_LOCK;
    end else begin
      case (st_q)
        bdm_pkg::ST_LOCK: begin
          st_d = bdm_pkg::ST_PWR;
        end
        bdm_pkg::ST_PWR: begin
          if (reg_ok) begin
            st_d = bdm_pkg::ST_WAIT;
          end
        end
        bdm_pkg::ST_WAIT: begin
          // Recheck before any switching
          if (chk_go) begin
            st_d = chk_bad ? bdm_pkg::ST_FLT : bdm_pkg::ST_SOFT;
          end
        end
        bdm_pkg::ST_SOFT: begin
          if (|qual_m) begin
            st_d = bdm_pkg::ST_FLT;
          end else if (!disable_fault_pin_i) begin
            st_d = bdm_pkg::ST_DIS;
          end else if (ss_q == 17'(SS_CYC - 1)) begin
            st_d = bdm_pkg::ST_RUN;
          end
        end
        bdm_pkg::ST_RUN: begin
          if (|qual_m) begin
            st_d = bdm_pkg::ST_FLT;
          end else if (!disable_fault_pin_i) begin
            st_d = bdm_pkg::ST_DIS;
          end
        end
        bdm_pkg::ST_DIS: begin
          if (|qual_m) begin
            st_d = bdm_pkg::ST_FLT;
          end else if (disable_fault_pin_i) begin
            st_d = bdm_pkg::ST_WAIT;
          end
        end
        bdm_pkg::ST_FLT: begin
          // Wait over, power up again, pin held low until the regulator is good
          if (rt_q == 22'(RETRY_CYC - 1)) begin
            st_d = bdm_pkg::ST_PWR;
          end
        end
        default: begin
          st_d = bdm_pkg::ST_LOCK;
        end
      endcase
    end
  end

  // Mode register
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= bdm_pkg::ST_LOCK;
    end else begin
      st_q <= st_d;
    end
  end

  // Fault latches, a new fault wins over the clear, bad trim drops the rest
  always_ff @(posedge mclk) begin
    if (reset) begin
      lat_q <= '0;
    end else begin
      lat_q <= ((clr ? '0 : lat_q) | set_v) & mask;
    end
  end

  // Trim check once after reset, on the first regulator-good power-up
  always_ff @(posedge mclk) begin
    if (reset) begin
      trim_q <= 1'b0;
      trim_seen_q <= 1'b0;
    end else if (st_q == bdm_pkg::ST_PWR && reg_ok && !trim_seen_q) begin
      trim_q <= trim_bad;
      trim_seen_q <= 1'b1;
    end
  end

  // Soft-start timer and frequency steps
  always_ff @(posedge mclk) begin
    if (reset || st_q != bdm_pkg::ST_SOFT) begin
      ss_q <= '0;
      sub_q <= '0;
      step_q <= 4'h0;
    end else begin
      ss_q <= ss_q + 17'h00001;
      if (sub_q == 17'(SUB_CYC - 1)) begin
        sub_q <= '0;
        if (step_q != 4'h8) begin
          step_q <= step_q + 4'h1;
        end
      end else begin
        sub_q <= sub_q + 17'h00001;
      end
    end
  end

  // Start at twice the frequency, widen the period step by step
  assign prod = 17'(freq_pin_code) * 17'(5'h08 + {1'b0, step_q});

  // Switching half period
  always_ff @(posedge mclk) begin
    if (reset) begin
      per_q <= 12'h000;
    end else if (st_q == bdm_pkg::ST_SOFT) begin
      per_q <= prod[15:4];
    end else begin
      per_q <= freq_pin_code;
    end
  end

  // Retry wait timer
  always_ff @(posedge mclk) begin
    if (reset || st_q != bdm_pkg::ST_FLT) begin
      rt_q <= '0;
    end else begin
      rt_q <= rt_q + 22'h000001;
    end
  end

  // Fault start and snapshot to the code sender
  assign cif.start = (st_d == bdm_pkg::ST_FLT) && (st_q != bdm_pkg::ST_FLT);
  assign cif.flags = (lat_q | set_v) & mask;

  bdm_send u_send (
    .mclk(mclk),
    .reset(reset),
    .cif(cif)
  );

  // Pin pull-down: power-up hold and coded fault train
  assign disable_fault_pin_o = 1'b0;
  assign disable_fault_pin_oe = (st_q == bdm_pkg::ST_PWR)
    || ((st_q == bdm_pkg::ST_FLT) && cif.pd);

  // Power stage and supply controls
  assign half_bridge_switch_node_en = (st_q == bdm_pkg::ST_SOFT)
    || (st_q == bdm_pkg::ST_RUN);
  assign sw_half_period = per_q;
  assign sw_sync_sel = (st_q == bdm_pkg::ST_RUN) && ctrl_q && sync_present;
  assign internal_regulator_en = (st_q != bdm_pkg::ST_LOCK);
  assign disabled_supply_current = (st_q == bdm_pkg::ST_DIS)
    || ((st_q == bdm_pkg::ST_FLT) && cif.done);

  // Wishbone answer one cycle after the request
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  always_ff @(posedge mclk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Control register write
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_q <= bdm_pkg::CTRL_RST;
    end else if (ack_q && wb_we_i && wb_sel_i[0] && wb_adr_i == bdm_pkg::REG_CTRL) begin
      ctrl_q <= wb_dat_i[bdm_pkg::CTRL_SYNC_BIT];
    end
  end

  // Read data, unmapped reads return zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      dat_q <= '0;
    end else if (req) begin
      dat_q <= '0;
      if (wb_adr_i == bdm_pkg::REG_CTRL) begin
        dat_q[bdm_pkg::CTRL_SYNC_BIT] <= ctrl_q;
      end else if (wb_adr_i == bdm_pkg::REG_STAT) begin
        dat_q[NF-1:0] <= lat_q;
        dat_q[bdm_pkg::STAT_ST_LSB +: 7] <= st_q;
      end
    end
  end
  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_fault_hit;
    (st_q == bdm_pkg::ST_SOFT || st_q == bdm_pkg::ST_RUN) && (|qual_m);
  endsequence
  sequence s_wait_over;
    st_q == bdm_pkg::ST_FLT && rt_q == 22'(RETRY_CYC - 1) && supply_ok;
  endsequence

  lock_idle_a: assert property (!supply_ok |=>
    !half_bridge_switch_node_en && !internal_regulator_en)
    else $error("switching or regulator on in lockout");
  soft_entry_a: assert property ($rose(st_q == bdm_pkg::ST_SOFT) |->
    $past(supply_ok && disable_fault_pin_i) && lat_q == '0)
    else $error("soft-start entered with fault or pin low");
  soft_len_a: assert property ($rose(st_q == bdm_pkg::ST_RUN) |->
    $past(ss_q) == 17'(SS_CYC - 1))
    else $error("soft-start interval wrong");
  soft_only_a: assert property ($rose(st_q == bdm_pkg::ST_RUN) |->
    $past(st_q) == bdm_pkg::ST_SOFT)
    else $error("normal run entered without soft-start");
  run_freq_a: assert property ((st_q == bdm_pkg::ST_RUN)[*2] |->
    sw_half_period == $past(freq_pin_code))
    else $error("run frequency not from frequency pin");
  dis_mode_a: assert property (st_q == bdm_pkg::ST_DIS |->
    internal_regulator_en && !half_bridge_switch_node_en && disabled_supply_current)
    else $error("disabled mode outputs wrong");
  fault_halt_a: assert property (s_fault_hit |=>
    st_q == bdm_pkg::ST_FLT && disable_fault_pin_oe && !half_bridge_switch_node_en)
    else $error("fault did not halt switching");
  low_cur_a: assert property ((st_q == bdm_pkg::ST_FLT && cif.done) |->
    disabled_supply_current && internal_regulator_en)
    else $error("low current not entered after codes");
  retry_a: assert property (s_wait_over |=> st_q == bdm_pkg::ST_PWR ##1
    !disable_fault_pin_oe || !reg_ok)
    else $error("pin not released after retry wait");
  recheck_a: assert property ((chk_go && chk_bad && supply_ok) |=>
    st_q == bdm_pkg::ST_FLT && !half_bridge_switch_node_en)
    else $error("recheck fault did not stop startup");
endmodule

//--- bdm_seq_tb.sv
// Self-checking bench of the mode and fault sequencer
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module bdm_seq_tb;
  // Shortened counts
  localparam int SS = 64;
  localparam int OC1 = 20;
  localparam int RTY = 24000;
  logic mclk = 0, reset = 1, supply_ok = 0, reg_ok = 0, trim_bad = 0, sync_present = 0;
  logic ocdt_check = 0, ocdt_high = 0, ocdt_mid = 0, hold = 0, oe_p = 0;
  logic pin, pin_o, pin_oe, sw_en, sync_sel, reg_en, low_i, cyc = 0, stb = 0, we = 0, ack;
  // Raw detectors: peak, overvoltage, low current, low on, temp, pin short, freq short
  logic [6:0] rw = 7'h00;
  logic [11:0] fcode = 12'h000, half;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  int err_total = 0, checks = 0, ncyc = 0, swn = 0, rec = 0;
  int edg[$];
  // Device under test
  bdm_seq #(.SS_CYC(SS), .OC1_CYC(OC1), .RETRY_CYC(RTY)) bdm_seq_i (.mclk(mclk),
    .reset(reset), .supply_ok(supply_ok), .reg_ok(reg_ok), .trim_bad(trim_bad),
    .oc_low(rw[2]), .ls_on(rw[3]), .oc_peak(rw[0]), .ov_det(rw[1]), .tsd_det(rw[4]),
    .ocdt_check(ocdt_check), .ocdt_high(ocdt_high), .ocdt_mid(ocdt_mid),
    .ocdt_low(rw[5]), .rt_low(rw[6]), .freq_pin_code(fcode), .sync_present(sync_present),
    .disable_fault_pin_i(pin), .disable_fault_pin_o(pin_o), .disable_fault_pin_oe(pin_oe),
    .half_bridge_switch_node_en(sw_en), .sw_half_period(half), .sw_sync_sel(sync_sel),
    .internal_regulator_en(reg_en), .disabled_supply_current(low_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack));
  // Host on the pin
  bdm_host #(.LAG(3)) bdm_host_i (.mclk(mclk), .hold(hold), .dev_o(pin_o),
    .dev_oe(pin_oe), .pin(pin));
  // Clock, 25 ns
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // Cycle count, switching count, pull-down edge log, timeout
  always @(posedge mclk) begin
    ncyc++;
    if (sw_en === 1'h1) swn++;
    if (rec != 0 && pin_oe !== oe_p) edg.push_back(ncyc);
    oe_p = pin_oe;
    if (ncyc == 90000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One classic bus cycle, result in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  // Raise one detector for n cycles
  task automatic pl(input int b, input int n);
    rw[b] <= 1'h1;
    wt(n);
    rw[b] <= 1'h0;
    wt(1);
  endtask
  // Soft-start half period at a step
  function automatic logic [11:0] ramp(input logic [11:0] t, input int s);
    return 12'((int'(t) * (8 + s)) / 16);
  endfunction
  // Pull-down rises in a train: entry, one per pulse, final hold
  function automatic int nrise(input logic [8:0] f);
    int n = 2;
    for (int i = 0; i < 9; i++) n += f[i] ? i + 1 : 0;
    return n;
  endfunction
  initial begin
    void'($urandom(97));
    fcode <= 12'(256 + $urandom_range(3839));
    wt(6);
    reset <= 1'h0;
    wt(2);
    `CHK("sw_en", 1'h0, sw_en)
    `CHK("reg_en", 1'h0, reg_en)
    wb(1'h0, bdm_pkg::REG_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, q)
    wb(1'h0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, q)
    // Just short of each qualification time
    pl(0, bdm_pkg::OC2_CYC);
    pl(1, bdm_pkg::OV_CYC);
    rw[3:2] <= 2'h3;
    wt(10);
    rw[3] <= 1'h0;
    wt(5);
    rw[3] <= 1'h1;
    wt(OC1 - 11);
    rw[3:2] <= 2'h0;
    wb(1'h0, bdm_pkg::REG_STAT, 32'h0);
    `CHK("short", 9'h000, q[8:0])
    pl(0, bdm_pkg::OC2_CYC + 1);
    pl(1, bdm_pkg::OV_CYC + 1);
    rw[3:2] <= 2'h3;
    wt(2);
    rw[3:2] <= 2'h0;
    wb(1'h0, bdm_pkg::REG_STAT, 32'h0);
    `CHK("qualified", 9'h007, q[8:0])
    // Power up with the pin held, then release into the fault
    hold <= 1'h1;
    supply_ok <= 1'h1;
    reg_ok <= 1'h1;
    wt(20);
    wb(1'h0, bdm_pkg::REG_STAT, 32'h0);
    `CHK("held", 7'h04, q[22:16])
    rec = 1;
    swn = 0;
    hold <= 1'h0;
    for (int i = 0; i < 22000 && low_i !== 1'h1; i++) wt(1);
    wt(2);
    `CHK("switching", 0, swn)
    `CHK("reg_on", 1'h1, reg_en)
    `CHK("edges", 2 * nrise(9'h007) - 1, edg.size())
    `CHK("delay", bdm_pkg::CODE_DLY_CYC, edg[1] - edg[0])
    `CHK("lead", bdm_pkg::LEAD_CYC, edg[2] - edg[1])
    `CHK("pulse", bdm_pkg::PULSE_CYC, edg[3] - edg[2])
    `CHK("gap", bdm_pkg::LEAD_CYC, edg[4] - edg[3])
    // Retry into soft-start, ramp then run
    for (int i = 0; i < RTY && sw_en !== 1'h1; i++) wt(1);
    wt(3);
    `CHK("ramp0", ramp(fcode, 0), half)
    wt(SS - 7);
    `CHK("ramp7", ramp(fcode, 7), half)
    wt(8);
    `CHK("period", fcode, half)
    wb(1'h0, bdm_pkg::REG_STAT, 32'h0);
    `CHK("run", 7'h10, q[22:16])
    sync_present <= 1'h1;
    wt(2);
    `CHK("sync", 1'h1, sync_sel)
    wb(1'h1, bdm_pkg::REG_CTRL, 32'h0);
    wt(2);
    `CHK("nosync", 1'h0, sync_sel)
    // External disable and re-enable
    hold <= 1'h1;
    wt(3);
    `CHK("dis_sw", 1'h0, sw_en)
    `CHK("dis_reg", 1'h1, reg_en)
    `CHK("dis_low", 1'h1, low_i)
    hold <= 1'h0;
    for (int i = 0; i < 100 && sw_en !== 1'h1; i++) wt(1);
    wb(1'h0, bdm_pkg::REG_STAT, 32'h0);
    `CHK("resoft", 7'h08, q[22:16])
    // Persistent temperature fault through one retry
    rw[4] <= 1'h1;
    wt(3);
    `CHK("halt", 1'h0, sw_en)
    `CHK("pull", 1'h1, pin_oe)
    swn = 0;
    wt(RTY + 200);
    wb(1'h0, bdm_pkg::REG_STAT, 32'h0);
    `CHK("refault", 7'h40, q[22:16])
    `CHK("tsd_flag", 1'h1, q[3])
    `CHK("idle", 0, swn)
    rw[4] <= 1'h0;
    for (int i = 0; i < RTY && sw_en !== 1'h1; i++) wt(1);
    `CHK("recover", 1'h1, sw_en)
    supply_ok <= 1'h0;
    wt(3);
    `CHK("lock_sw", 1'h0, sw_en)
    `CHK("lock_reg", 1'h0, reg_en)
    // Pin faults latch even in lockout
    ocdt_check <= 1'h1;
    ocdt_mid <= 1'h1;
    rw[6:5] <= 2'h3;
    wt(1);
    ocdt_check <= 1'h0;
    ocdt_high <= 1'h1;
    wt(1);
    wb(1'h0, bdm_pkg::REG_STAT, 32'h0);
    `CHK("pins", 9'h0f0, q[8:0])
    // Bad trim masks every other fault
    reset <= 1'h1;
    trim_bad <= 1'h1;
    rw[4] <= 1'h1;
    wt(6);
    reset <= 1'h0;
    supply_ok <= 1'h1;
    wt(600);
    wb(1'h0, bdm_pkg::REG_STAT, 32'h0);
    `CHK("trim", 9'h100, q[8:0])
    `CHK("trim_st", 7'h40, q[22:16])
    print_verdict();
  end
endmodule
